/* File: design/sfsd_defines.svh */
// opcode bytes, field values and clock counts for the string/flag/system decoder
// Notes on behaviour
// [RL1] equal-repeat compare string: 5 or 7+7c clocks
// [RL2] unequal-repeat compare string: 5 or 7+7c clocks
// [RL3] repeated load string: 5 clocks at zero count
// [RL4] repeated move string: 5, 13 at one
// [RL5] equal-repeat scan string: 5 or 7+5c clocks
// [RL6] unequal-repeat scan string: same timing as equal
// [RL7] repeated store string: 5 or 7+4c clocks
// [RL8] carry invert takes 2 clocks, flips carry
// [RL9] interrupt enable clear/set, 5 clocks each
// [RL10] high acc to flags 2, reverse 3
// [RL11] unpacked add/sub adjust, 3 clocks each
// [RL12] unpacked multiply adjust d4 0a, 15 clocks
// [RL13] unpacked divide adjust d5 0a, 14 clocks
// [RL14] packed add/sub adjust, 2 clocks each
// [RL15] control register zero write: 17, +2 miss
// [RL16] test register three: read 3, write 4
// [RL17] task switched clear: 7 clocks, +2 miss
// [RL18] cache invalidate 4, writeback invalidate 5 clocks
// [RL19] tlb entry invalidate: 12 hit, 11 miss
// [RL20] address, operand, lock prefixes: 1 clock
// [RL21] six segment override prefixes: 1 clock
// [RL22] halt stops execution, 4 clocks
// [RL23] w bit picks byte or sized element
`ifndef SFSD_DEFINES_SVH
`define SFSD_DEFINES_SVH
`define SFSD_B_REP_EQ 8'hf3
`define SFSD_B_REP_NE 8'hf2
`define SFSD_B_CMP_STR 7'h53
`define SFSD_B_LOAD_STR 7'h56
`define SFSD_B_MOVE_STR 7'h52
`define SFSD_B_SCAN_STR 7'h57
`define SFSD_B_STORE_STR 7'h55
`define SFSD_B_CARRY_INV 8'hf5
`define SFSD_B_IE_CLR 8'hfa
`define SFSD_B_IE_SET 8'hfb
`define SFSD_B_ACC_TO_FLAGS 8'h9e
`define SFSD_B_FLAGS_TO_ACC 8'h9f
`define SFSD_B_UADD 8'h37
`define SFSD_B_USUB 8'h3f
`define SFSD_B_UMUL 8'hd4
`define SFSD_B_UDIV 8'hd5
`define SFSD_B_BASE10 8'h0a
`define SFSD_B_PADD 8'h27
`define SFSD_B_PSUB 8'h2f
`define SFSD_B_HALT 8'hf4
`define SFSD_B_ESC 8'h0f
`define SFSD_B_CRW 8'h22
`define SFSD_B_TRR 8'h24
`define SFSD_B_TRW 8'h26
`define SFSD_B_TSCLR 8'h06
`define SFSD_B_CACHE_INV 8'h08
`define SFSD_B_CACHE_WBINV 8'h09
`define SFSD_B_GRP7 8'h01
`define SFSD_MID_CTRL0 3'h0
`define SFSD_MID_TEST3 3'h3
`define SFSD_MID_TLB_INV 3'h7
`define SFSD_MOD_REG 2'h3
`define SFSD_B_ASIZE 8'h67
`define SFSD_B_OSIZE 8'h66
`define SFSD_B_LOCK 8'hf0
`define SFSD_B_SEG_CS 8'h2e
`define SFSD_B_SEG_DS 8'h3e
`define SFSD_B_SEG_ES 8'h26
`define SFSD_B_SEG_FS 8'h64
`define SFSD_B_SEG_GS 8'h65
`define SFSD_B_SEG_SS 8'h36
`define SFSD_CK_ZERO 36'h5
`define SFSD_CK_STR_BASE 36'h7
`define SFSD_CK_MOVE_ONE 36'hd
`define SFSD_CK_MOVE_BASE 36'hc
`define SFSD_CK_2 36'h2
`define SFSD_CK_3 36'h3
`define SFSD_CK_4 36'h4
`define SFSD_CK_5 36'h5
`define SFSD_CK_7 36'h7
`define SFSD_CK_UMUL 36'hf
`define SFSD_CK_UDIV 36'he
`define SFSD_CK_CTRL0 36'h11
`define SFSD_CK_MISS 36'h2
`define SFSD_CK_TLB_HIT 36'hc
`define SFSD_CK_TLB_MISS 36'hb
`define SFSD_CK_PREFIX 36'h1
`endif

/* File: design/sfsd_pkg.sv */
// types shared by the string/flag/system decoder
package sfsd_pkg;
  typedef enum logic [4:0] {
    SFSD_OP_NONE, SFSD_OP_OTHER, SFSD_OP_PREFIX,
    SFSD_OP_CMP_STR_EQ, SFSD_OP_CMP_STR_NE, SFSD_OP_LOAD_STR, SFSD_OP_MOVE_STR,
    SFSD_OP_SCAN_STR_EQ, SFSD_OP_SCAN_STR_NE, SFSD_OP_STORE_STR,
    SFSD_OP_CARRY_INV, SFSD_OP_IE_CLR, SFSD_OP_IE_SET,
    SFSD_OP_ACC_TO_FLAGS, SFSD_OP_FLAGS_TO_ACC,
    SFSD_OP_UADD, SFSD_OP_USUB, SFSD_OP_UMUL, SFSD_OP_UDIV,
    SFSD_OP_PADD, SFSD_OP_PSUB, SFSD_OP_CTRL0_WR, SFSD_OP_TEST3_RD,
    SFSD_OP_TEST3_WR, SFSD_OP_TS_CLR, SFSD_OP_CACHE_INV, SFSD_OP_CACHE_WBINV,
    SFSD_OP_TLB_INV, SFSD_OP_HALT
  } sfsd_op_t;
  typedef enum logic [2:0] {
    SFSD_SEG_NONE, SFSD_SEG_CS, SFSD_SEG_DS, SFSD_SEG_ES,
    SFSD_SEG_FS, SFSD_SEG_GS, SFSD_SEG_SS
  } sfsd_seg_t;
endpackage

/* File: design/sfsd_time_if.sv */
// link from the decoder to its clock-count calculator
`timescale 1ns/1ps
`default_nettype none
interface sfsd_time_if;
  import sfsd_pkg::*;
  sfsd_op_t op;
  logic [31:0] count;
  logic miss;
  logic tlb_hit;
  logic [35:0] clocks;
  modport dec (output op, output count, output miss, output tlb_hit, input clocks);
  modport calc (input op, input count, input miss, input tlb_hit, output clocks);
endinterface // sfsd_time_if
`default_nettype wire

/* File: design/sfsd_timing.sv */
// clock count for each decoded operation, with cache-miss adders and tlb hit/miss counts
`timescale 1ns/1ps
`default_nettype none
`include "sfsd_defines.svh"
module sfsd_timing
  import sfsd_pkg::*;
(
  sfsd_time_if.calc t
);
  logic [35:0] c;
  logic zero;
  assign c = {4'h0, t.count};
  assign zero = (t.count == 32'h0);
  always_comb begin
    t.clocks = 36'h0;
    unique case (t.op)
      SFSD_OP_CMP_STR_EQ, SFSD_OP_CMP_STR_NE:
        t.clocks = zero ? `SFSD_CK_ZERO : `SFSD_CK_STR_BASE + 36'(7 * c); // RL1 RL2
      SFSD_OP_SCAN_STR_EQ, SFSD_OP_SCAN_STR_NE:
        t.clocks = zero ? `SFSD_CK_ZERO : `SFSD_CK_STR_BASE + 36'(5 * c); // RL5 RL6
      SFSD_OP_LOAD_STR, SFSD_OP_STORE_STR:
        t.clocks = zero ? `SFSD_CK_ZERO : `SFSD_CK_STR_BASE + 36'(4 * c); // RL3 RL7
      SFSD_OP_MOVE_STR: begin
        if (zero) t.clocks = `SFSD_CK_ZERO; // RL4
        else if (t.count == 32'h1) t.clocks = `SFSD_CK_MOVE_ONE; // RL4
        else t.clocks = `SFSD_CK_MOVE_BASE + 36'(3 * c);
      end
      SFSD_OP_CARRY_INV, SFSD_OP_ACC_TO_FLAGS: t.clocks = `SFSD_CK_2; // RL8 RL10
      SFSD_OP_FLAGS_TO_ACC: t.clocks = `SFSD_CK_3; // RL10
      SFSD_OP_IE_CLR, SFSD_OP_IE_SET: t.clocks = `SFSD_CK_5; // RL9
      SFSD_OP_UADD, SFSD_OP_USUB: t.clocks = `SFSD_CK_3; // RL11
      SFSD_OP_UMUL: t.clocks = `SFSD_CK_UMUL; // RL12
      SFSD_OP_UDIV: t.clocks = `SFSD_CK_UDIV; // RL13
      SFSD_OP_PADD, SFSD_OP_PSUB: t.clocks = `SFSD_CK_2; // RL14
      SFSD_OP_CTRL0_WR: t.clocks = `SFSD_CK_CTRL0 + (t.miss ? `SFSD_CK_MISS : 36'h0); // RL15
      SFSD_OP_TEST3_RD: t.clocks = `SFSD_CK_3; // RL16
      SFSD_OP_TEST3_WR: t.clocks = `SFSD_CK_4; // RL16
      SFSD_OP_TS_CLR: t.clocks = `SFSD_CK_7 + (t.miss ? `SFSD_CK_MISS : 36'h0); // RL17
      SFSD_OP_CACHE_INV: t.clocks = `SFSD_CK_4; // RL18
      SFSD_OP_CACHE_WBINV: t.clocks = `SFSD_CK_5; // RL18
      SFSD_OP_TLB_INV: t.clocks = t.tlb_hit ? `SFSD_CK_TLB_HIT : `SFSD_CK_TLB_MISS; // RL19
      SFSD_OP_PREFIX: t.clocks = `SFSD_CK_PREFIX; // RL20 RL21
      SFSD_OP_HALT: t.clocks = `SFSD_CK_4; // RL22
      default: t.clocks = 36'h0;
    endcase
  end
endmodule // sfsd_timing
`default_nettype wire

/* File: design/sfsd_decode.sv */
// instruction byte decoder for string, flag, decimal, control and prefix groups
`timescale 1ns/1ps
`default_nettype none
`include "sfsd_defines.svh"
module sfsd_decode
  import sfsd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic [31:0] count_register_i,
  input wire logic op32_i,
  input wire logic cache_miss_i,
  input wire logic tlb_hit_i,
  input wire logic resume_i,
  input wire logic task_switched_set_i,
  output logic byte_ready_o,
  output logic issue_valid_o,
  output sfsd_op_t issue_op_o,
  output logic [35:0] issue_clocks_o,
  output logic [2:0] elem_bytes_o,
  output sfsd_seg_t issue_seg_o,
  output logic issue_lock_o,
  output logic issue_addr32_o,
  output logic issue_op32_o,
  output logic carry_o,
  output logic irq_enable_o,
  output logic task_switched_o,
  output logic halted_o
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_REP = 6'h02,
    ST_ESC = 6'h04,
    ST_MODRM = 6'h08,
    ST_BASE10 = 6'h10,
    ST_HALT = 6'h20
  } sfsd_state_t;

  sfsd_state_t st_reg, st_next;
  sfsd_op_t op_next;
  sfsd_seg_t seg_reg, seg_next, seg_code;
  logic [7:0] sec_reg, sec_next;
  logic rep_ne_reg, rep_ne_next;
  logic lock_reg, lock_next, asize_reg, asize_next, osize_reg, osize_next;
  logic take, fire, is_pfx, is_str;
  logic [2:0] elem_next;
  sfsd_time_if tif ();

  sfsd_timing u_timing (
    .t(tif)
  );

  assign take = ce_i && byte_valid_i && byte_ready_o;
  assign is_str = (byte_i[7:1] == `SFSD_B_CMP_STR) || (byte_i[7:1] == `SFSD_B_LOAD_STR) ||
    (byte_i[7:1] == `SFSD_B_MOVE_STR) || (byte_i[7:1] == `SFSD_B_SCAN_STR) ||
    (byte_i[7:1] == `SFSD_B_STORE_STR);

  // segment code of an override byte, none otherwise
  always_comb begin
    seg_code = SFSD_SEG_NONE;
    unique case (byte_i)
      `SFSD_B_SEG_CS: seg_code = SFSD_SEG_CS; // RL21
      `SFSD_B_SEG_DS: seg_code = SFSD_SEG_DS;
      `SFSD_B_SEG_ES: seg_code = SFSD_SEG_ES;
      `SFSD_B_SEG_FS: seg_code = SFSD_SEG_FS;
      `SFSD_B_SEG_GS: seg_code = SFSD_SEG_GS;
      `SFSD_B_SEG_SS: seg_code = SFSD_SEG_SS;
      default: seg_code = SFSD_SEG_NONE;
    endcase
  end

  assign is_pfx = (seg_code != SFSD_SEG_NONE) || (byte_i == `SFSD_B_ASIZE) ||
    (byte_i == `SFSD_B_OSIZE) || (byte_i == `SFSD_B_LOCK); // RL20 RL21

  // next state and the operation that leaves this cycle
  always_comb begin
    st_next = st_reg;
    op_next = SFSD_OP_NONE;
    fire = 1'b0;
    sec_next = sec_reg;
    rep_ne_next = rep_ne_reg;
    if (st_reg == ST_HALT) begin
      if (resume_i) st_next = ST_IDLE;
    end else if (take) begin
      unique case (st_reg)
        ST_IDLE, ST_REP: begin
          if (is_pfx) begin
            fire = 1'b1;
            op_next = SFSD_OP_PREFIX; // RL20 RL21
          end else if (byte_i == `SFSD_B_REP_EQ || byte_i == `SFSD_B_REP_NE) begin
            st_next = ST_REP;
            rep_ne_next = (byte_i == `SFSD_B_REP_NE);
          end else if (st_reg == ST_REP) begin
            fire = 1'b1;
            st_next = ST_IDLE;
            op_next = SFSD_OP_OTHER;
            if (byte_i[7:1] == `SFSD_B_CMP_STR)
              op_next = rep_ne_reg ? SFSD_OP_CMP_STR_NE : SFSD_OP_CMP_STR_EQ; // RL1 RL2
            else if (byte_i[7:1] == `SFSD_B_SCAN_STR)
              op_next = rep_ne_reg ? SFSD_OP_SCAN_STR_NE : SFSD_OP_SCAN_STR_EQ; // RL5 RL6
            else if (byte_i[7:1] == `SFSD_B_LOAD_STR) op_next = SFSD_OP_LOAD_STR; // RL3
            else if (byte_i[7:1] == `SFSD_B_MOVE_STR) op_next = SFSD_OP_MOVE_STR; // RL4
            else if (byte_i[7:1] == `SFSD_B_STORE_STR) op_next = SFSD_OP_STORE_STR; // RL7
          end else begin
            fire = 1'b1;
            unique case (byte_i)
              `SFSD_B_CARRY_INV: op_next = SFSD_OP_CARRY_INV; // RL8
              `SFSD_B_IE_CLR: op_next = SFSD_OP_IE_CLR; // RL9
              `SFSD_B_IE_SET: op_next = SFSD_OP_IE_SET; // RL9
              `SFSD_B_ACC_TO_FLAGS: op_next = SFSD_OP_ACC_TO_FLAGS; // RL10
              `SFSD_B_FLAGS_TO_ACC: op_next = SFSD_OP_FLAGS_TO_ACC; // RL10
              `SFSD_B_UADD: op_next = SFSD_OP_UADD; // RL11
              `SFSD_B_USUB: op_next = SFSD_OP_USUB; // RL11
              `SFSD_B_PADD: op_next = SFSD_OP_PADD; // RL14
              `SFSD_B_PSUB: op_next = SFSD_OP_PSUB; // RL14
              `SFSD_B_HALT: begin
                op_next = SFSD_OP_HALT; // RL22
                st_next = ST_HALT;
              end
              `SFSD_B_UMUL, `SFSD_B_UDIV: begin
                fire = 1'b0;
                sec_next = byte_i;
                st_next = ST_BASE10;
              end
              `SFSD_B_ESC: begin
                fire = 1'b0;
                st_next = ST_ESC;
              end
              default: op_next = SFSD_OP_OTHER;
            endcase
          end
        end
        ST_BASE10: begin
          fire = 1'b1;
          st_next = ST_IDLE;
          if (byte_i != `SFSD_B_BASE10) op_next = SFSD_OP_OTHER;
          else if (sec_reg == `SFSD_B_UMUL) op_next = SFSD_OP_UMUL; // RL12
          else op_next = SFSD_OP_UDIV; // RL13
        end
        ST_ESC: begin
          fire = 1'b1;
          st_next = ST_IDLE;
          unique case (byte_i)
            `SFSD_B_CRW, `SFSD_B_TRR, `SFSD_B_TRW, `SFSD_B_GRP7: begin
              fire = 1'b0;
              sec_next = byte_i;
              st_next = ST_MODRM;
            end
            `SFSD_B_TSCLR: op_next = SFSD_OP_TS_CLR; // RL17
            `SFSD_B_CACHE_INV: op_next = SFSD_OP_CACHE_INV; // RL18
            `SFSD_B_CACHE_WBINV: op_next = SFSD_OP_CACHE_WBINV; // RL18
            default: op_next = SFSD_OP_OTHER;
          endcase
        end
        ST_MODRM: begin
          fire = 1'b1;
          st_next = ST_IDLE;
          op_next = SFSD_OP_OTHER;
          if (byte_i[7:6] == `SFSD_MOD_REG) begin
            if (sec_reg == `SFSD_B_CRW && byte_i[5:3] == `SFSD_MID_CTRL0)
              op_next = SFSD_OP_CTRL0_WR; // RL15
            else if (sec_reg == `SFSD_B_TRR && byte_i[5:3] == `SFSD_MID_TEST3)
              op_next = SFSD_OP_TEST3_RD; // RL16
            else if (sec_reg == `SFSD_B_TRW && byte_i[5:3] == `SFSD_MID_TEST3)
              op_next = SFSD_OP_TEST3_WR; // RL16
          end else if (sec_reg == `SFSD_B_GRP7 && byte_i[5:3] == `SFSD_MID_TLB_INV) begin
            op_next = SFSD_OP_TLB_INV; // RL19
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  // pending prefix attributes, dropped once an instruction issues
  always_comb begin
    seg_next = seg_reg;
    lock_next = lock_reg;
    asize_next = asize_reg;
    osize_next = osize_reg;
    if (fire && op_next == SFSD_OP_PREFIX) begin
      if (seg_code != SFSD_SEG_NONE) seg_next = seg_code; // RL21
      if (byte_i == `SFSD_B_LOCK) lock_next = 1'b1; // RL20
      if (byte_i == `SFSD_B_ASIZE) asize_next = 1'b1; // RL20
      if (byte_i == `SFSD_B_OSIZE) osize_next = 1'b1; // RL20
    end else if (fire) begin
      seg_next = SFSD_SEG_NONE;
      lock_next = 1'b0;
      asize_next = 1'b0;
      osize_next = 1'b0;
    end
  end

  // element width from the w bit and the operand-size attribute
  always_comb begin
    elem_next = 3'h0;
    if (st_reg == ST_REP && is_str) begin
      if (!byte_i[0]) elem_next = 3'h1; // RL23
      else elem_next = (op32_i ^ osize_reg) ? 3'h4 : 3'h2; // RL23
    end
  end

  assign tif.op = op_next;
  assign tif.count = count_register_i;
  assign tif.miss = cache_miss_i;
  assign tif.tlb_hit = tlb_hit_i;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
      sec_reg <= 8'h00;
      rep_ne_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      sec_reg <= sec_next;
      rep_ne_reg <= rep_ne_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seg_reg <= SFSD_SEG_NONE;
      lock_reg <= 1'b0;
      asize_reg <= 1'b0;
      osize_reg <= 1'b0;
    end else if (ce_i) begin
      seg_reg <= seg_next;
      lock_reg <= lock_next;
      asize_reg <= asize_next;
      osize_reg <= osize_next;
    end
  end

  // issue port toward the execution pipeline
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      issue_valid_o <= 1'b0;
      issue_op_o <= SFSD_OP_NONE;
      issue_clocks_o <= 36'h0;
      elem_bytes_o <= 3'h0;
      issue_seg_o <= SFSD_SEG_NONE;
      issue_lock_o <= 1'b0;
      issue_addr32_o <= 1'b0;
      issue_op32_o <= 1'b0;
    end else if (ce_i) begin
      issue_valid_o <= fire;
      if (fire) begin
        issue_op_o <= op_next;
        issue_clocks_o <= tif.clocks;
        elem_bytes_o <= elem_next;
        issue_seg_o <= (op_next == SFSD_OP_PREFIX) ? seg_next : seg_reg;
        issue_lock_o <= lock_reg;
        issue_addr32_o <= asize_reg;
        issue_op32_o <= op32_i ^ osize_reg;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_ready_o <= 1'b1;
      halted_o <= 1'b0;
    end else if (ce_i) begin
      byte_ready_o <= (st_next != ST_HALT); // RL22
      halted_o <= (st_next == ST_HALT); // RL22
    end
  end

  // flag state touched by this group
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_o <= 1'b0;
      irq_enable_o <= 1'b0;
      task_switched_o <= 1'b0;
    end else if (ce_i) begin
      if (fire && op_next == SFSD_OP_CARRY_INV) carry_o <= !carry_o; // RL8
      if (fire && op_next == SFSD_OP_IE_CLR) irq_enable_o <= 1'b0; // RL9
      if (fire && op_next == SFSD_OP_IE_SET) irq_enable_o <= 1'b1; // RL9
      if (task_switched_set_i) task_switched_o <= 1'b1;
      else if (fire && op_next == SFSD_OP_TS_CLR) task_switched_o <= 1'b0; // RL17
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_idle_byte(logic [7:0] b);
    take && st_reg == ST_IDLE && byte_i == b;
  endsequence
  sequence s_rep_str(logic [7:0] p, logic [6:0] s);
    take && st_reg == ST_IDLE && byte_i == p ##1 take && byte_i[7:1] == s;
  endsequence

  a_cmp_timing: assert property (s_rep_str(`SFSD_B_REP_NE, `SFSD_B_CMP_STR) |=> // RL2
    issue_op_o == SFSD_OP_CMP_STR_NE && issue_clocks_o ==
    (($past(count_register_i) == 32'h0) ? 36'h5 :
    36'h7 + 36'(7 * {4'h0, $past(count_register_i)})))
    else $error("unequal compare string count wrong");
  a_move_one: assert property (s_rep_str(`SFSD_B_REP_EQ, `SFSD_B_MOVE_STR) ##0
    count_register_i == 32'h1 |=> issue_clocks_o == 36'hd) // RL4
    else $error("move string of one not 13 clocks");
  a_rep_zero: assert property (s_rep_str(`SFSD_B_REP_EQ, `SFSD_B_STORE_STR) ##0
    count_register_i == 32'h0 |=> issue_valid_o && issue_clocks_o == 36'h5) // RL7
    else $error("zero count store string not 5 clocks");
  a_elem_byte: assert property (s_rep_str(`SFSD_B_REP_EQ, `SFSD_B_LOAD_STR) ##0 !byte_i[0]
    |=> elem_bytes_o == 3'h1) // RL23
    else $error("w clear did not give byte element");
  a_carry_flip: assert property (s_idle_byte(`SFSD_B_CARRY_INV) |=> // RL8
    issue_clocks_o == 36'h2 && carry_o != $past(carry_o))
    else $error("carry invert wrong");
  a_irq_clear: assert property (s_idle_byte(`SFSD_B_IE_CLR) |=>
    !irq_enable_o && issue_clocks_o == 36'h5) // RL9
    else $error("interrupt enable clear wrong");
  a_mul_adjust: assert property (s_idle_byte(`SFSD_B_UMUL) ##1 take &&
    byte_i == `SFSD_B_BASE10 |=> issue_op_o == SFSD_OP_UMUL && issue_clocks_o == 36'hf) // RL12
    else $error("multiply adjust wrong");
  a_prefix_one: assert property (take && st_reg == ST_IDLE && is_pfx |=>
    issue_valid_o && issue_clocks_o == 36'h1) // RL20
    else $error("prefix not one clock");
  a_halt_stops: assert property (s_idle_byte(`SFSD_B_HALT) |=> // RL22
    halted_o && !byte_ready_o && issue_clocks_o == 36'h4 ##1 ($past(resume_i) || !byte_ready_o))
    else $error("halt did not stop fetch");
  a_ts_clear: assert property (take && st_reg == ST_ESC && byte_i == `SFSD_B_TSCLR &&
    !task_switched_set_i |=> !task_switched_o &&
    issue_clocks_o == (36'h7 + ($past(cache_miss_i) ? 36'h2 : 36'h0))) // RL17
    else $error("task switched clear wrong");
endmodule // sfsd_decode
`default_nettype wire

/* File: bench/sfsd_prefetch_model.sv */
// prefetch-side byte source feeding the decoder one byte per handshake
`timescale 1ns/1ps
`default_nettype none
module sfsd_prefetch_model (
  input wire logic sys_clk_i,
  input wire logic ce_i,
  input wire logic byte_ready_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // present a byte and hold it until the edge that takes it
  task automatic send(input logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 1'b1;
    byte_valid_o = 1'b1;
    byte_o = b;
    while (!(byte_ready_i && ce_i) && n < 100) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 100) ok = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask
  // released bus shows the inverse of the last byte, never a stale copy
  task automatic idle();
    byte_valid_o = 1'b0;
    byte_o = ~byte_o;
  endtask
endmodule // sfsd_prefetch_model
`default_nettype wire

/* File: bench/test_string_flag_sysctl_decode.sv */
// self-checking bench for the string/flag/system decoder
`timescale 1ns/1ps
`default_nettype none
module test_string_flag_sysctl_decode;
  import sfsd_pkg::*;
  logic sys_clk_i, rst_i, ce_i, op32_i, cache_miss_i, tlb_hit_i, resume_i, ts_set;
  logic byte_valid, byte_ready, issue_valid, carry, irqen, ts, halted, lock, a32, o32;
  logic [7:0] bval;
  logic [31:0] count, rs, x;
  logic [35:0] clocks;
  logic [2:0] elem;
  sfsd_op_t iop;
  sfsd_seg_t seg;
  int n_fail, n_compared, k;
  logic [7:0] pre [7] = '{8'hf3, 8'hf2, 8'hf3, 8'hf3, 8'hf3, 8'hf2, 8'hf3};
  logic [6:0] op7 [7] = '{7'h53, 7'h53, 7'h56, 7'h52, 7'h57, 7'h57, 7'h55};
  int form [7] = '{0, 0, 2, 3, 1, 1, 2};
  sfsd_op_t sop [7] = '{SFSD_OP_CMP_STR_EQ, SFSD_OP_CMP_STR_NE, SFSD_OP_LOAD_STR,
    SFSD_OP_MOVE_STR, SFSD_OP_SCAN_STR_EQ, SFSD_OP_SCAN_STR_NE, SFSD_OP_STORE_STR};
  logic [7:0] pfx [9] = '{8'h67, 8'h66, 8'hf0, 8'h2e, 8'h3e, 8'h26, 8'h64, 8'h65, 8'h36};
  sfsd_seg_t pseg [9] = '{SFSD_SEG_NONE, SFSD_SEG_NONE, SFSD_SEG_NONE, SFSD_SEG_CS,
    SFSD_SEG_DS, SFSD_SEG_ES, SFSD_SEG_FS, SFSD_SEG_GS, SFSD_SEG_SS};

  sfsd_decode i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .byte_valid_i(byte_valid),
    .byte_i(bval), .count_register_i(count), .op32_i(op32_i), .cache_miss_i(cache_miss_i),
    .tlb_hit_i(tlb_hit_i), .resume_i(resume_i), .task_switched_set_i(ts_set),
    .byte_ready_o(byte_ready), .issue_valid_o(issue_valid), .issue_op_o(iop),
    .issue_clocks_o(clocks), .elem_bytes_o(elem), .issue_seg_o(seg), .issue_lock_o(lock),
    .issue_addr32_o(a32), .issue_op32_o(o32), .carry_o(carry), .irq_enable_o(irqen),
    .task_switched_o(ts), .halted_o(halted)
  );
  sfsd_prefetch_model i_pf (
    .sys_clk_i(sys_clk_i), .ce_i(ce_i), .byte_ready_i(byte_ready),
    .byte_valid_o(byte_valid), .byte_o(bval)
  );

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // repeated string clock count from kind and repeat count
  function automatic logic [35:0] sclk(input int f, input logic [31:0] c);
    logic [35:0] cc;
    cc = {4'h0, c};
    if (c == 32'h0) return 36'h5;
    case (f)
      0: return 36'h7 + 36'h7 * cc;
      1: return 36'h7 + 36'h5 * cc;
      2: return 36'h7 + 36'h4 * cc;
      default: return (c == 32'h1) ? 36'hd : 36'hc + 36'h3 * cc;
    endcase
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // send n bytes, then check the one-cycle issue that follows
  task automatic op(input logic [7:0] b0, b1, b2, input int n, input sfsd_op_t e,
      input logic [35:0] ck);
    bit ok;
    logic [7:0] b [3];
    b = '{b0, b1, b2};
    for (int i = 0; i < n; i++) begin
      i_pf.send(b[i], ok);
      if (!ok) chk(36'h0, 36'h1);
    end
    chk(issue_valid, 1'b1);
    chk(iop, e);
    chk(clocks, ck);
    i_pf.idle();
    @(posedge sys_clk_i);
    #1;
    chk(issue_valid, 1'b0);
  endtask
  task automatic test_done();
    $display("counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #500000;
    n_fail++;
    test_done();
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    count = 32'h0;
    op32_i = 1'b0;
    cache_miss_i = 1'b0;
    tlb_hit_i = 1'b0;
    resume_i = 1'b0;
    ts_set = 1'b0;
    rs = 32'h16a794ce;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    chk(byte_ready, 1'b1);
    for (int r = 0; r < 42; r++) begin
      k = r % 7;
      x = rnd();
      count = r < 7 ? 32'h0 : r < 14 ? 32'h1 : r < 21 ? 32'hffffffff : x & 32'hff;
      op32_i = x[8];
      op(pre[k], {op7[k], x[9]}, 8'h00, 2, sop[k], sclk(form[k], count));
      chk(elem, !x[9] ? 3'h1 : x[8] ? 3'h4 : 3'h2);
    end
    op(8'hf3, 8'h66, 8'ha5, 3, SFSD_OP_MOVE_STR, sclk(3, count));
    chk(elem, op32_i ? 3'h2 : 3'h4);
    $display("test string ops done");
    for (int i = 0; i < 2; i++) begin
      op(8'hf5, 8'h00, 8'h00, 1, SFSD_OP_CARRY_INV, 36'h2);
      chk(carry, (i == 0));
    end
    op(8'hfb, 8'h00, 8'h00, 1, SFSD_OP_IE_SET, 36'h5);
    chk(irqen, 1'b1);
    op(8'hfa, 8'h00, 8'h00, 1, SFSD_OP_IE_CLR, 36'h5);
    chk(irqen, 1'b0);
    op(8'h9e, 8'h00, 8'h00, 1, SFSD_OP_ACC_TO_FLAGS, 36'h2);
    op(8'h9f, 8'h00, 8'h00, 1, SFSD_OP_FLAGS_TO_ACC, 36'h3);
    op(8'h37, 8'h00, 8'h00, 1, SFSD_OP_UADD, 36'h3);
    op(8'h3f, 8'h00, 8'h00, 1, SFSD_OP_USUB, 36'h3);
    op(8'hd4, 8'h0a, 8'h00, 2, SFSD_OP_UMUL, 36'hf);
    op(8'hd4, 8'h55, 8'h00, 2, SFSD_OP_OTHER, 36'h0);
    op(8'hd5, 8'h0a, 8'h00, 2, SFSD_OP_UDIV, 36'he);
    op(8'h27, 8'h00, 8'h00, 1, SFSD_OP_PADD, 36'h2);
    op(8'h2f, 8'h00, 8'h00, 1, SFSD_OP_PSUB, 36'h2);
    $display("test flag and decimal ops done");
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      cache_miss_i = x[0];
      tlb_hit_i = x[1];
      op(8'h0f, 8'h22, 8'hc0, 3, SFSD_OP_CTRL0_WR, x[0] ? 36'h13 : 36'h11);
      op(8'h0f, 8'h24, 8'hd8, 3, SFSD_OP_TEST3_RD, 36'h3);
      op(8'h0f, 8'h26, 8'hd8, 3, SFSD_OP_TEST3_WR, 36'h4);
      ts_set = 1'b1;
      @(posedge sys_clk_i);
      #1;
      ts_set = 1'b0;
      chk(ts, 1'b1);
      op(8'h0f, 8'h06, 8'h00, 2, SFSD_OP_TS_CLR, x[0] ? 36'h9 : 36'h7);
      chk(ts, 1'b0);
      op(8'h0f, 8'h08, 8'h00, 2, SFSD_OP_CACHE_INV, 36'h4);
      op(8'h0f, 8'h09, 8'h00, 2, SFSD_OP_CACHE_WBINV, 36'h5);
      op(8'h0f, 8'h01, 8'h38, 3, SFSD_OP_TLB_INV, x[1] ? 36'hc : 36'hb);
    end
    $display("test control ops done");
    for (int i = 0; i < 9; i++) begin
      x = rnd();
      op32_i = x[0];
      op(pfx[i], 8'h00, 8'h00, 1, SFSD_OP_PREFIX, 36'h1);
      op(8'hf5, 8'h00, 8'h00, 1, SFSD_OP_CARRY_INV, 36'h2);
      chk(seg, pseg[i]);
      chk(lock, (i == 2));
      chk(a32, (i == 0));
      chk(o32, x[0] ^ (i == 1));
    end
    $display("test prefixes done");
    op(8'hf4, 8'h00, 8'h00, 1, SFSD_OP_HALT, 36'h4);
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk(halted, 1'b1);
    chk(byte_ready, 1'b0);
    resume_i = 1'b1;
    ce_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(byte_ready, 1'b0);
    chk(halted, 1'b1);
    ce_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    resume_i = 1'b0;
    chk(byte_ready, 1'b1);
    chk(halted, 1'b0);
    $display("test halt done");
    test_done();
  end
endmodule // test_string_flag_sysctl_decode
`default_nettype wire
